// *** common/ssio_map.vh ***
// Purpose: Register map and constants of the synchronous serial unit.
// Assumes: Word-aligned APB byte addresses, 32-bit data.
// Notes:   Definitions only.
`ifndef SSIO_MAP_VH
`define SSIO_MAP_VH

// -----------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------
`define SSIO_OFS_CTRL1   4'h0
`define SSIO_OFS_DBUF    4'h4
`define SSIO_OFS_STAT    4'h8
`define SSIO_OFS_IDLE    4'hC

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define SSIO_BIT_START   7
`define SSIO_BIT_ABORT   6
`define SSIO_BIT_MODE_HI 5
`define SSIO_BIT_MODE_LO 4
`define SSIO_BIT_ACTIVE  3
`define SSIO_BIT_SHIFT   2
`define SSIO_BIT_IDLERUN 6

// -----------------------------------------------------------------
// Encodings and reset values
// -----------------------------------------------------------------
`define SSIO_MODE_TX     2'b00
`define SSIO_MODE_DUPLEX 2'b10
`define SSIO_MODE_RX     2'b11
`define SSIO_CLK_EXT     3'b111
`define SSIO_CTRL1_RST   8'h00
`define SSIO_IDLE_ONES   8'hBE
`define SSIO_STAT_ONES   8'hF3
`define SSIO_DUMMY       8'hFF

// -----------------------------------------------------------------
// Timing: internal clock half period is 2^(n) pclk cycles.
// -----------------------------------------------------------------
`define SSIO_N_BASE      4'd3
`define SSIO_N_SEL6      4'd9
`define SSIO_BITS        3'd7

`endif

// *** rtl/ssio_top.v ***
// Purpose: Synchronous serial (shift) mode of a serial bus unit.
// Assumes: pclk at 10 MHz; link pins are asynchronous to pclk.
// Notes:   APB slave with zero wait states; one design file.
`timescale 1ns/10ps
`default_nettype none
`include "ssio_map.vh"

// Function
// - Idle run bit 6: 0 stops unit in idle mode, 1 keeps it running.
// - Clock select 111 uses external serial clock, else internal clock.
// - Seven internal clock rates, driven out on the serial clock pin.
// - Serial clock pin output goes high when a transfer begins.
// - Internal clock halts until software services the data buffer.
// - Transmit bits change on falling edge, receive sampled on rising.
// - Two-bit mode field picks transmit, receive or duplex.
// - Write first byte, set start; byte shifts out LSB first.
// - Byte moved to shifter marks buffer empty and interrupts.
// - Internal transmit waits after 8 bits until buffer written.
// - Output holds previous last bit until first falling edge.
// - Clearing start in transmit finishes data, then drops active.
// - Abort ends any transfer at once, clears active flag.
// - External clock: start left set sends dummy byte, then stops.
// - Receive shifts LSB first; after 8 bits buffer full, interrupt.
// - Internal receive halts clock until received byte is read.
// - Clearing start in receive/duplex ends after current byte stored.
// - Mode change discards buffer; software ends transfer first.
// - Duplex: out on fall, in on rise, interrupt per byte.
// - Internal duplex waits for read and new write.
// - Active flag reads 1 during transfer, 0 when complete.
module ssio_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        idle_mode,
    input  wire        serial_clock_pin_in,
    output reg         serial_clock_pin_out,
    output reg         serial_clock_pin_oe,
    output reg         serial_out,
    input  wire        serial_in,
    output reg         buffer_interrupt
);

    // -------------------------------------------------------------
    // States
    // -------------------------------------------------------------
    localparam [1:0] ST_IDLE  = 2'd0;
    localparam [1:0] ST_WAIT  = 2'd1;
    localparam [1:0] ST_SHIFT = 2'd2;

    // -------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------
    reg  [1:0] state_q;
    reg        start_q;
    reg        abort_q;
    reg  [1:0] mode_q;
    reg  [2:0] clk_sel_q;
    reg        idle_run_q;
    reg  [7:0] tx_buf_q;
    reg        tx_full_q;
    reg  [7:0] rx_buf_q;
    reg        rx_full_q;
    reg  [7:0] tx_sh_q;
    reg  [7:0] rx_sh_q;
    reg  [2:0] bit_cnt_q;
    reg        last_q;
    reg  [8:0] div_q;
    reg        sck_s1_q;
    reg        sck_s2_q;
    reg        sck_s3_q;
    reg        si_s1_q;
    reg        si_s2_q;
    reg  [8:0] half_lim;
    reg  [3:0] n_sel;
    reg  [7:0] rd_byte;
    reg        map_hit;
    wire       setup_ph;
    wire       wr_acc;
    wire       rd_acc;
    wire [3:0] ofs;
    wire       ext_clk;
    wire       run_en;
    wire       tx_mode;
    wire       rx_mode;
    wire       ready_go;
    wire       fall_evt;
    wire       rise_evt;
    wire       int_tick;
    wire       wr_ctrl;
    wire       wr_dbuf;
    wire       rd_dbuf;
    wire       mode_chg;
    wire       byte_end;
    wire       stop_evt;

    // -------------------------------------------------------------
    // Bus decode
    // -------------------------------------------------------------
    // Requests are taken in the access phase; reads are prepared in
    // the setup phase so the slave never needs a wait state.
    assign setup_ph = psel & ~penable;
    assign wr_acc   = psel & penable & pwrite;
    assign rd_acc   = psel & penable & ~pwrite;
    assign ofs      = paddr[3:0];
    assign wr_ctrl  = wr_acc & (paddr[11:4] == 8'h00)
                    & (ofs == `SSIO_OFS_CTRL1);
    assign wr_dbuf  = wr_acc & (paddr[11:4] == 8'h00)
                    & (ofs == `SSIO_OFS_DBUF);
    assign rd_dbuf  = rd_acc & (paddr[11:4] == 8'h00)
                    & (ofs == `SSIO_OFS_DBUF);
    // Changing the mode field throws the buffered bytes away.
    assign mode_chg = wr_ctrl & (pwdata[5:4] != mode_q);

    // Read mux; reserved bits read as the map requires.
    always @* begin
        map_hit = (paddr[11:4] == 8'h00);
        rd_byte = 8'h00;
        case (ofs)
            `SSIO_OFS_CTRL1: rd_byte = {start_q, abort_q, mode_q,
                                        1'b1, clk_sel_q};
            `SSIO_OFS_DBUF:  rd_byte = rx_buf_q;
            `SSIO_OFS_STAT:  rd_byte = `SSIO_STAT_ONES
                                     | {4'h0, (state_q != ST_IDLE),
                                        (state_q == ST_SHIFT), 2'b00};
            `SSIO_OFS_IDLE:  rd_byte = `SSIO_IDLE_ONES
                                     | {1'b0, idle_run_q, 6'h00};
            default:         map_hit = 1'b0;
        endcase
    end

    // Registered bus answer; unmapped words read zero with an error.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b1;
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            prdata  <= {24'h00_0000, map_hit ? rd_byte : 8'h00};
            pslverr <= ~map_hit;
            pready  <= 1'b1;
        end
    end

    // -------------------------------------------------------------
    // Control registers
    // -------------------------------------------------------------
    // Start, abort, mode and clock select; start drops on its own
    // when the engine finishes the dummy byte.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_q    <= 1'b0;
            abort_q    <= 1'b0;
            mode_q     <= 2'b00;
            clk_sel_q  <= 3'b000;
            idle_run_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                start_q   <= pwdata[`SSIO_BIT_START];
                abort_q   <= pwdata[`SSIO_BIT_ABORT];
                mode_q    <= pwdata[5:4];
                clk_sel_q <= pwdata[2:0];
            end else if (stop_evt) begin
                // After the dummy byte the unit stays stopped.
                start_q <= 1'b0;
            end
            // Bit 0 of the idle word is not stored: it must read 0.
            if (wr_acc && map_hit && ofs == `SSIO_OFS_IDLE) begin
                idle_run_q <= pwdata[`SSIO_BIT_IDLERUN];
            end
        end
    end

    // -------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------
    // Two flops per pin; a third stage on the clock finds edges.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_s1_q <= 1'b1;
            sck_s2_q <= 1'b1;
            sck_s3_q <= 1'b1;
            si_s1_q  <= 1'b0;
            si_s2_q  <= 1'b0;
        end else begin
            sck_s1_q <= serial_clock_pin_in;
            sck_s2_q <= sck_s1_q;
            sck_s3_q <= sck_s2_q;
            si_s1_q  <= serial_in;
            si_s2_q  <= si_s1_q;
        end
    end

    // -------------------------------------------------------------
    // Clock source and edges
    // -------------------------------------------------------------
    assign ext_clk = (clk_sel_q == `SSIO_CLK_EXT);
    // Idle mode freezes the engine, all but abort and mode change, unless run bit set.
    assign run_en  = ~(idle_mode & ~idle_run_q);
    assign tx_mode = (mode_q == `SSIO_MODE_TX)
                   | (mode_q == `SSIO_MODE_DUPLEX);
    assign rx_mode = (mode_q == `SSIO_MODE_RX)
                   | (mode_q == `SSIO_MODE_DUPLEX);

    // Seven rates: half period of 2^n cycles, n = 3..9.
    always @* begin
        n_sel = `SSIO_N_BASE + {1'b0, clk_sel_q};
        if (clk_sel_q == 3'b110) begin
            n_sel = `SSIO_N_SEL6;
        end
        half_lim = 9'h1FF >> (4'd9 - n_sel);
    end

    assign int_tick = ~ext_clk & (div_q == half_lim);
    // External edges come from synchronised samples.
    assign fall_evt = ext_clk ? (sck_s3_q & ~sck_s2_q)
                              : (int_tick & serial_clock_pin_out);
    assign rise_evt = ext_clk ? (~sck_s3_q & sck_s2_q)
                              : (int_tick & ~serial_clock_pin_out);
    assign byte_end = rise_evt & (bit_cnt_q == `SSIO_BITS);
    // A stored start would restart at once, so the last byte drops it.
    assign stop_evt = run_en & ~abort_q & ~mode_chg & (state_q == ST_SHIFT)
                    & byte_end & last_q;

    // Internal clock waits while software is behind.
    // Transmit needs a new byte, receive needs a read.
    assign ready_go = (~tx_mode | tx_full_q) & (~rx_mode | ~rx_full_q);

    // -------------------------------------------------------------
    // Shift engine
    // -------------------------------------------------------------
    // External clock never stalls: a missing byte becomes a dummy
    // and the unit stops after it, so the far end sees no hang.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q              <= ST_IDLE;
            tx_sh_q              <= 8'h00;
            rx_sh_q              <= 8'h00;
            bit_cnt_q            <= 3'd0;
            last_q               <= 1'b0;
            div_q                <= 9'd0;
            serial_clock_pin_out <= 1'b1;
            serial_out           <= 1'b1;
            buffer_interrupt     <= 1'b0;
        end else begin
            buffer_interrupt <= 1'b0;
            if (abort_q || mode_chg) begin
                // Abort kills the transfer at once.
                state_q              <= ST_IDLE;
                serial_clock_pin_out <= 1'b1;
                div_q                <= 9'd0;
            end else if (run_en) begin
                case (state_q)
                    ST_IDLE: begin
                        if (start_q) begin
                            // Clock pin parks high.
                            serial_clock_pin_out <= 1'b1;
                            last_q               <= 1'b0;
                            state_q              <= ST_WAIT;
                        end
                    end
                    ST_WAIT: begin
                        div_q <= 9'd0;
                        if (!start_q) begin
                            // Wind-down done.
                            state_q <= ST_IDLE;
                        end else if (ready_go || ext_clk) begin
                            // Load buffer into shifter.
                            bit_cnt_q <= 3'd0;
                            state_q   <= ST_SHIFT;
                            if (tx_mode) begin
                                tx_sh_q <= tx_full_q ? tx_buf_q
                                                     : `SSIO_DUMMY;
                            end
                            // Dummy byte is the last one.
                            last_q <= ext_clk & ~ready_go;
                            // Buffer empty interrupt.
                            if (mode_q == `SSIO_MODE_TX) begin
                                buffer_interrupt <= tx_full_q;
                            end
                        end
                    end
                    ST_SHIFT: begin
                        if (int_tick) begin
                            div_q <= 9'd0;
                            serial_clock_pin_out <= ~serial_clock_pin_out;
                        end else if (!ext_clk) begin
                            div_q <= div_q + 9'd1;
                        end
                        // Output only moves on a falling edge, so the
                        // old last bit holds until then.
                        if (fall_evt && tx_mode) begin
                            serial_out <= tx_sh_q[0];
                        end
                        if (rise_evt) begin
                            // LSB first in and out.
                            tx_sh_q   <= {1'b1, tx_sh_q[7:1]};
                            rx_sh_q   <= {si_s2_q, rx_sh_q[7:1]};
                            bit_cnt_q <= bit_cnt_q + 3'd1;
                        end
                        if (byte_end) begin
                            if (rx_mode) begin
                                buffer_interrupt <= 1'b1;
                            end
                            // Stop after the current byte.
                            state_q <= (last_q || !start_q) ? ST_IDLE
                                                            : ST_WAIT;
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // -------------------------------------------------------------
    // Data buffer
    // -------------------------------------------------------------
    // Separate write and read halves; a hardware set wins over a
    // software clear in the same cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_buf_q  <= 8'h00;
            tx_full_q <= 1'b0;
            rx_buf_q  <= 8'h00;
            rx_full_q <= 1'b0;
        end else if (mode_chg) begin
            // Contents are not kept over a mode change.
            tx_full_q <= 1'b0;
            rx_full_q <= 1'b0;
            rx_buf_q  <= 8'h00;
        end else begin
            if (wr_dbuf) begin
                tx_buf_q  <= pwdata[7:0];
                tx_full_q <= 1'b1;
            end else if (run_en && !abort_q && state_q == ST_WAIT
                         && start_q && tx_mode
                         && (ready_go || ext_clk)) begin
                tx_full_q <= 1'b0;
            end
            if (run_en && !abort_q && state_q == ST_SHIFT
                && byte_end && rx_mode) begin
                // Completed byte lands in the buffer.
                rx_buf_q  <= {si_s2_q, rx_sh_q[7:1]};
                rx_full_q <= 1'b1;
            end else if (rd_dbuf) begin
                rx_full_q <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------
    // Clock pin direction
    // -------------------------------------------------------------
    // The pin is driven only when the clock is made here.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_clock_pin_oe <= 1'b0;
        end else begin
            serial_clock_pin_oe <= ~ext_clk;
        end
    end

endmodule
`default_nettype wire

// *** dv/ssio_peer.sv ***
// Purpose: Behavioural serial peripheral on the clock and data pins.
// Assumes: Shifts LSB first, drives on falling and samples on rising edges.
// Notes:   Makes the external clock only inside frames, high otherwise.
`timescale 1ns/10ps
`default_nettype none
module ssio_peer (
    input  wire logic sck,
    input  wire logic sdo,
    output var logic  sdi,
    output var logic  ext_sck
);
    logic [7:0] tx_byte;
    logic [7:0] rx_q;
    logic [2:0] cnt;
    int         nrise;

    // ---------------------------------------------------------------
    // Shifting
    // ---------------------------------------------------------------
    // The external clock stands high between frames.
    initial begin
        ext_sck = 1'b1;
        sdi = 1'b1;
        tx_byte = 8'h00;
        rx_q = 8'h00;
        cnt = 3'd0;
        nrise = 0;
    end
    // Next bit goes out on each falling edge, LSB first.
    always @(negedge sck) begin
        sdi = tx_byte[cnt];
        cnt = cnt + 3'd1;
    end
    // Unit data is taken on each rising edge, LSB first.
    always @(posedge sck) begin
        rx_q = {sdo, rx_q[7:1]};
        nrise = nrise + 1;
    end
    // Loads a new byte and clears the edge count.
    task automatic arm(input logic [7:0] b);
        tx_byte = b;
        cnt = 3'd0;
        nrise = 0;
    endtask
    // Offset from pclk so pin edges never meet its sampling edge.
    task automatic pulse(input int n);
        #130;
        repeat (n) begin
            ext_sck = 1'b0;
            #400;
            ext_sck = 1'b1;
            #400;
        end
    endtask
endmodule
`default_nettype wire

// *** dv/ssio_assertions.sv ***
// Purpose: Port-level checks of the serial unit.
// Assumes: One pclk domain, presetn active low.
// Notes:   Bound into the top module below.
`timescale 1ns/10ps
`default_nettype none
module ssio_assertions (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        idle_mode,
    input wire logic        serial_clock_pin_in,
    input wire logic        serial_clock_pin_out,
    input wire logic        serial_clock_pin_oe,
    input wire logic        serial_out,
    input wire logic        serial_in,
    input wire logic        buffer_interrupt
);
    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // The slave never inserts wait states.
    zero_wait_a: assert property (psel |-> pready)
        else $error("pready low during a transfer");
    unmapped_err_a: assert property (psel && !penable |=>
        pslverr == (($past(paddr[11:4]) != 8'h00) || ($past(paddr[1:0]) != 2'b00)))
        else $error("pslverr does not follow the address map");
    upper_zero_a: assert property (psel && penable |-> prdata[31:8] == 24'h00_0000)
        else $error("read data above bit 7 not zero");
    idle_ones_a: assert property (psel && !penable && !pwrite && paddr == 12'h00C |=>
        (prdata[7:0] | 8'h40) == 8'hFE)
        else $error("idle control fixed bits wrong");
    status_ones_a: assert property (psel && !penable && !pwrite && paddr == 12'h008 |=>
        (prdata[7:0] & 8'hF3) == 8'hF3)
        else $error("status fixed bits wrong");
    clock_source_a: assert property (psel && penable && pwrite && paddr == 12'h000 |=>
        ##1 serial_clock_pin_oe == ($past(pwdata[2:0], 2) != 3'b111))
        else $error("clock pin enable does not follow the source select");
    // Data may only move while the internal clock is low.
    out_on_fall_a: assert property (serial_clock_pin_oe && $changed(serial_out) |->
        !serial_clock_pin_out)
        else $error("serial data changed while clock high");
    low_phase_a: assert property ($fell(serial_clock_pin_out) |-> !serial_clock_pin_out[*8])
        else $error("serial clock low phase shorter than 8 cycles");
    high_phase_a: assert property ($rose(serial_clock_pin_out) |-> serial_clock_pin_out[*8])
        else $error("serial clock high phase shorter than 8 cycles");
    irq_pulse_a: assert property (buffer_interrupt |=> !buffer_interrupt)
        else $error("buffer interrupt longer than one cycle");
endmodule
bind ssio_top ssio_assertions u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .idle_mode(idle_mode),
    .serial_clock_pin_in(serial_clock_pin_in),
    .serial_clock_pin_out(serial_clock_pin_out),
    .serial_clock_pin_oe(serial_clock_pin_oe), .serial_out(serial_out),
    .serial_in(serial_in), .buffer_interrupt(buffer_interrupt)
);
`default_nettype wire

// *** dv/ssio_top_test.sv ***
// Purpose: Register-level tests of the serial unit against a peer model.
// Assumes: pclk period 100 ns, external serial clock period 800 ns.
// Notes:   Interrupt pulses are counted and compared per scenario.
`timescale 1ns/10ps
`default_nettype none
`include "ssio_map.vh"
module ssio_top_test;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        idle_mode;
    logic [31:0] rdat;
    logic        rerr;
    int          err_count = 0;
    int          checked = 0;
    int          irq_n = 0;
    wire  [31:0] prdata;
    wire         pready, pslverr, sck_out, sck_oe;
    wire         serial_out, serial_in, ext_sck, buffer_interrupt;
    // The pin carries whichever party drives it.
    wire         sck = sck_oe ? sck_out : ext_sck;

    ssio_top dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .idle_mode(idle_mode),
        .serial_clock_pin_in(sck), .serial_clock_pin_out(sck_out),
        .serial_clock_pin_oe(sck_oe), .serial_out(serial_out),
        .serial_in(serial_in), .buffer_interrupt(buffer_interrupt)
    );
    ssio_peer peer (.sck(sck), .sdo(serial_out), .sdi(serial_in), .ext_sck(ext_sck));

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // One APB transfer; waits on pready, never on a fixed count.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdat, e);
    endtask
    // Waits for n clock rises, then lets a stall show before counting.
    task automatic bits(input int n);
        int k;
        for (k = 0; k < 5000 && peer.nrise < n; k++) @(posedge pclk);
        repeat (300) @(posedge pclk);
        chk(peer.nrise, n);
    endtask
    task complete_run();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Processes
    // ---------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // Pulses are one cycle, so each high sample is one event.
    always @(posedge pclk) begin
        if (buffer_interrupt === 1'b1) irq_n <= irq_n + 1;
    end
    // Whole run needs about 2200 cycles; 40000 means a hang.
    initial begin
        #4_000_000;
        err_count++;
        complete_run();
    end
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        idle_mode = 1'b1;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // Pin edges seen while reset settles must not count as bits.
        peer.arm(8'h00);
        rd(`SSIO_OFS_IDLE, 32'h0000_00BE);
        rd(`SSIO_OFS_STAT, 32'h0000_00F3);
        rd(12'h010, 32'h0000_0000);
        chk(rerr, 1'b1);
        // Transmit, internal clock; idle mode with run bit clear freezes it.
        wr(`SSIO_OFS_DBUF, 32'h0000_00A5);
        wr(`SSIO_OFS_CTRL1, 32'h0000_0080);
        repeat (200) @(posedge pclk);
        chk(peer.nrise, 0);
        idle_mode <= 1'b0;
        bits(8);
        chk(peer.rx_q, 8'hA5);
        chk(irq_n, 1);
        apb(1'b0, `SSIO_OFS_STAT, 32'h0000_0000);
        chk(rdat[3], 1'b1);
        wr(`SSIO_OFS_DBUF, 32'h0000_003C);
        chk(serial_out, 1'b1);
        wr(`SSIO_OFS_CTRL1, 32'h0000_0000);
        bits(16);
        chk(peer.rx_q, 8'h3C);
        chk(irq_n, 2);
        rd(`SSIO_OFS_STAT, 32'h0000_00F3);
        // Receive, internal clock, kept running in idle by the run bit.
        wr(`SSIO_OFS_IDLE, 32'h0000_0040);
        rd(`SSIO_OFS_IDLE, 32'h0000_00FE);
        idle_mode <= 1'b1;
        peer.arm(8'h96);
        wr(`SSIO_OFS_CTRL1, 32'h0000_00B0);
        bits(8);
        chk(irq_n, 3);
        rd(`SSIO_OFS_DBUF, 32'h0000_0096);
        wr(`SSIO_OFS_CTRL1, 32'h0000_0030);
        bits(16);
        rd(`SSIO_OFS_STAT, 32'h0000_00F3);
        rd(`SSIO_OFS_DBUF, 32'h0000_0096);
        idle_mode <= 1'b0;
        // Duplex with the external clock: exchange, dummy byte, abort.
        peer.arm(8'hC3);
        wr(`SSIO_OFS_CTRL1, 32'h0000_0027);
        // The pin enable follows the stored select one cycle later.
        repeat (2) @(posedge pclk);
        chk(sck_oe, 1'b0);
        wr(`SSIO_OFS_DBUF, 32'h0000_005A);
        wr(`SSIO_OFS_CTRL1, 32'h0000_00A7);
        peer.pulse(8);
        repeat (20) @(posedge pclk);
        chk(peer.rx_q, 8'h5A);
        chk(irq_n, 5);
        rd(`SSIO_OFS_DBUF, 32'h0000_00C3);
        peer.pulse(8);
        repeat (20) @(posedge pclk);
        chk(peer.rx_q, `SSIO_DUMMY);
        rd(`SSIO_OFS_STAT, 32'h0000_00F3);
        wr(`SSIO_OFS_DBUF, 32'h0000_0011);
        wr(`SSIO_OFS_CTRL1, 32'h0000_00A7);
        peer.pulse(3);
        wr(`SSIO_OFS_CTRL1, 32'h0000_0067);
        rd(`SSIO_OFS_STAT, 32'h0000_00F3);
        complete_run();
    end
endmodule
`default_nettype wire
